// ---- core/timer_pkg.sv ----
// constants for the prescaled down timer with its multi-function pin
package timer_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_MAIN_PERIOD = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_MAIN_COUNT = 2'h3;
  // control register bit positions
  localparam int B_STOP = 0;
  localparam int B_LOAD = 1;
  localparam int B_AUTO = 2;
  localparam int B_CP = 3;
  localparam int B_SENSE = 4;
  localparam int B_PW_LO = 5;
  localparam int B_ROLE_LO = 7;
  localparam int B_DRIVE = 9;
  localparam int B_ERR = 10;
  // prescale register: period in low nibble, live count above it
  localparam int B_PPER_LO = 0;
  localparam int B_PCNT_LO = 4;
  // pin roles
  localparam logic [1:0] ROLE_OFF = 2'h0;
  localparam logic [1:0] ROLE_TOUT = 2'h1;
  localparam logic [1:0] ROLE_GPO = 2'h2;
  localparam logic [1:0] ROLE_EXT = 2'h3;
  // reset values
  localparam logic [3:0] RST_PSC = 4'h0;
  localparam logic [15:0] RST_TIM = 16'hFFFF;
  localparam logic [3:0] RST_PSC_PER = 4'h0;
  localparam logic [15:0] RST_TIM_PER = 16'hFFFF;
endpackage : timer_pkg

// ---- core/prescaled_down_timer_pin.sv ----
// prescaled down timer with interrupt, dma event and multi-function pin
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module prescaled_down_timer_pin
  import timer_pkg::*;
(
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic [ADDR_W-1:0] regAddr, // register index
  input wire logic [DATA_W-1:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [DATA_W-1:0] regRdata, // read data, cycle after strobe
  input wire logic timerPinIn, // timer_pin level seen at the pad
  output logic timerPinOut, // timer_pin drive level
  output logic timerPinOe, // timer_pin output enable
  output logic timerIrq, // timer_irq pulse
  output logic dmaSyncEvent // dma_sync_event pulse
);

  typedef struct packed {
    logic timerStop;
    logic loadEnable;
    logic autoReload;
    logic clockOrPulseSel;
    logic outputLevelSense;
    logic [1:0] pulseLengthSel;
    logic [1:0] pinRoleSelect;
    logic pinDriveValue;
    logic modeErrorFlag;
    logic [3:0] prescalePeriod;
    logic [3:0] prescaleCount;
    logic [15:0] mainPeriod;
    logic [15:0] mainCount;
    logic irq;
    logic pinOut;
    logic pinOe;
    logic clkState;
    logic [3:0] pulseCnt;
    logic pinSync1;
    logic pinSync2;
    logic pinPrev;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [3:0] pulseWidth(input logic [1:0] sel);
    case (sel)
      2'h0: pulseWidth = 4'h1;
      2'h1: pulseWidth = 4'h2;
      2'h2: pulseWidth = 4'h4;
      default: pulseWidth = 4'h8;
    endcase
  endfunction : pulseWidth

  function automatic logic roleLegal(input logic [1:0] cur,
                                     input logic [1:0] nxt);
    if (cur == nxt || cur == ROLE_OFF)
      roleLegal = 1'b1;
    else if (cur == ROLE_EXT)
      roleLegal = 1'b0;
    else
      roleLegal = (nxt == ROLE_TOUT) || (nxt == ROLE_GPO);
  endfunction : roleLegal

  logic extEdge;
  logic tick;
  logic terminal;
  logic [1:0] wrRole;

  // the first sync flop feeds only the second
  assign extEdge = st_r.pinSync2 & ~st_r.pinPrev;
  assign tick = (st_r.pinRoleSelect == ROLE_EXT)
                ? extEdge : 1'b1;
  assign terminal = tick && !st_r.timerStop && !st_r.loadEnable
                    && st_r.prescaleCount == 4'h0
                    && st_r.mainCount == 16'h0;
  assign wrRole = regWdata[B_ROLE_LO+:2];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.pinSync1 = timerPinIn;
    st_nxt.pinSync2 = st_r.pinSync1;
    st_nxt.pinPrev = st_r.pinSync2;
    // counting
    if (st_r.loadEnable)
    begin
      st_nxt.prescaleCount = st_r.prescalePeriod;
      st_nxt.mainCount = st_r.mainPeriod;
    end
    else if (!st_r.timerStop && tick)
    begin
      if (st_r.prescaleCount != 4'h0)
        st_nxt.prescaleCount = st_r.prescaleCount - 4'h1;
      else
      begin
        st_nxt.prescaleCount = st_r.prescalePeriod;
        if (st_r.mainCount != 16'h0)
          st_nxt.mainCount = st_r.mainCount - 16'h1;
        else
        begin
          st_nxt.irq = 1'b1;
          st_nxt.mainCount = st_r.mainPeriod;
          if (!st_r.autoReload)
            st_nxt.timerStop = 1'b1;
        end
      end
    end
    // pin waveform state
    if (st_r.pulseCnt != 4'h0)
      st_nxt.pulseCnt = st_r.pulseCnt - 4'h1;
    if (terminal)
    begin
      st_nxt.pulseCnt = pulseWidth(st_r.pulseLengthSel);
      st_nxt.clkState = ~st_r.clkState;
    end
    // register writes
    if (regWr)
    begin
      case (regAddr)
        OFS_CTRL:
        begin
          st_nxt.timerStop = regWdata[B_STOP];
          st_nxt.loadEnable = regWdata[B_LOAD];
          st_nxt.autoReload = regWdata[B_AUTO];
          st_nxt.clockOrPulseSel = regWdata[B_CP];
          st_nxt.outputLevelSense = regWdata[B_SENSE];
          st_nxt.pulseLengthSel = regWdata[B_PW_LO+:2];
          st_nxt.pinDriveValue = regWdata[B_DRIVE];
          if (roleLegal(st_r.pinRoleSelect, wrRole))
            st_nxt.pinRoleSelect = wrRole;
          else
            st_nxt.modeErrorFlag = 1'b1;
        end
        OFS_PRESCALE:
          st_nxt.prescalePeriod = regWdata[B_PPER_LO+:4];
        OFS_MAIN_PERIOD:
          st_nxt.mainPeriod = regWdata;
        OFS_MAIN_COUNT:
          st_nxt.mainCount = regWdata;
        default:
          st_nxt.mainPeriod = st_r.mainPeriod;
      endcase
    end
    // pin drive
    case (st_nxt.pinRoleSelect)
      ROLE_TOUT:
      begin
        st_nxt.pinOe = 1'b1;
        if (st_nxt.clockOrPulseSel)
          st_nxt.pinOut = st_nxt.clkState ^ st_nxt.outputLevelSense;
        else
          st_nxt.pinOut = (st_nxt.pulseCnt != 4'h0)
                          ^ st_nxt.outputLevelSense;
      end
      ROLE_GPO:
      begin
        st_nxt.pinOe = 1'b1;
        st_nxt.pinOut = st_nxt.pinDriveValue;
      end
      default:
      begin
        st_nxt.pinOe = 1'b0;
        st_nxt.pinOut = 1'b0;
      end
    endcase
    // read data, valid the cycle after the strobe
    st_nxt.rdata = '0;
    if (regRd)
    begin
      case (regAddr)
        OFS_CTRL:
        begin
          st_nxt.rdata[B_STOP] = st_r.timerStop;
          st_nxt.rdata[B_LOAD] = st_r.loadEnable;
          st_nxt.rdata[B_AUTO] = st_r.autoReload;
          st_nxt.rdata[B_CP] = st_r.clockOrPulseSel;
          st_nxt.rdata[B_SENSE] = st_r.outputLevelSense;
          st_nxt.rdata[B_PW_LO+:2] = st_r.pulseLengthSel;
          st_nxt.rdata[B_ROLE_LO+:2] = st_r.pinRoleSelect;
          st_nxt.rdata[B_DRIVE] = st_r.pinDriveValue;
          st_nxt.rdata[B_ERR] = st_r.modeErrorFlag;
        end
        OFS_PRESCALE:
        begin
          st_nxt.rdata[B_PPER_LO+:4] = st_r.prescalePeriod;
          st_nxt.rdata[B_PCNT_LO+:4] = st_r.prescaleCount;
        end
        OFS_MAIN_PERIOD:
          st_nxt.rdata = st_r.mainPeriod;
        default:
          st_nxt.rdata = st_r.mainCount;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.timerStop <= 1'b1;
      st_r.prescaleCount <= RST_PSC;
      st_r.mainCount <= RST_TIM;
      st_r.prescalePeriod <= RST_PSC_PER;
      st_r.mainPeriod <= RST_TIM_PER;
    end
    else
      st_r <= st_nxt;
  end

  assign regRdata = st_r.rdata;
  assign timerPinOut = st_r.pinOut;
  assign timerPinOe = st_r.pinOe;
  assign timerIrq = st_r.irq;
  assign dmaSyncEvent = st_r.irq;

  // checks, all on the system clock
  default clocking cbSys @(posedge sys_clk);
  endclocking

  default disable iff (!nrst);

  sequence sTerm;
    terminal && !regWr;
  endsequence

  sequence sEventOut;
    timerIrq && dmaSyncEvent;
  endsequence

  property pTermEvent;
    sTerm |=> sEventOut;
  endproperty

  a_term_event: assert property (pTermEvent)
    else $error("terminal count gave no irq and dma event");

  a_load_enable: assert property (
    st_r.loadEnable && !regWr
    |=> st_r.prescaleCount == $past(st_r.prescalePeriod)
    && st_r.mainCount == $past(st_r.mainPeriod))
    else $error("load enable did not copy periods");

  a_stop_freeze: assert property (
    st_r.timerStop && !st_r.loadEnable && !regWr
    |=> $stable(st_r.prescaleCount) && $stable(st_r.mainCount))
    else $error("counters moved while stopped");

  a_prescale_dec: assert property (
    tick && !st_r.timerStop && !st_r.loadEnable && !regWr
    && st_r.prescaleCount != 4'h0
    |=> st_r.prescaleCount == $past(st_r.prescaleCount) - 4'h1)
    else $error("prescale count did not step down");

  a_main_dec: assert property (
    tick && !st_r.timerStop && !st_r.loadEnable && !regWr
    && st_r.prescaleCount == 4'h0 && st_r.mainCount != 16'h0
    |=> st_r.mainCount == $past(st_r.mainCount) - 16'h1
    && st_r.prescaleCount == $past(st_r.prescalePeriod))
    else $error("main count did not step after prescale zero");

  a_one_shot: assert property (
    sTerm and !st_r.autoReload |=> st_r.timerStop ##1 !timerIrq)
    else $error("one shot kept counting");

  a_auto_reload: assert property (
    sTerm and st_r.autoReload
    |=> !st_r.timerStop && st_r.mainCount == $past(st_r.mainPeriod))
    else $error("auto reload missed");

  a_pin_role: assert property (
    st_r.pinRoleSelect == ROLE_OFF || st_r.pinRoleSelect == ROLE_EXT
    |-> !timerPinOe)
    else $error("pin driven in a non-output role");

  a_gpo_level: assert property (
    st_r.pinRoleSelect == ROLE_GPO && !regWr
    |=> timerPinOe && timerPinOut == $past(st_r.pinDriveValue))
    else $error("general output level wrong");

  // a write or a new terminal in the pulse cycle may reshape the pin
  a_pulse_one: assert property (
    sTerm and st_r.pinRoleSelect == ROLE_TOUT && !st_r.clockOrPulseSel
    && st_r.pulseLengthSel == 2'h0
    |=> timerPinOut != st_r.outputLevelSense
    ##1 ($past(regWr) || $past(terminal)
    || timerPinOut == st_r.outputLevelSense))
    else $error("single cycle pulse wrong");

  a_error_sticky: assert property (
    st_r.modeErrorFlag |=> st_r.modeErrorFlag)
    else $error("mode error flag cleared");

  a_ext_locked: assert property (
    st_r.pinRoleSelect == ROLE_EXT
    |=> st_r.pinRoleSelect == ROLE_EXT)
    else $error("left external clock role");

endmodule : prescaled_down_timer_pin

// ---- tb/timer_far_side.sv ----
// far side model: irq and dma event sinks plus an external pin clock
`timescale 1ns/1ps
module timer_far_side
(
  input wire logic sys_clk, // system clock
  input wire logic nrst, // reset, active low
  input wire logic timerIrq, // interrupt request
  input wire logic dmaSyncEvent, // dma event
  input wire logic extRun, // run the pin clock
  output logic extClk, // clock offered on the pin
  output logic [15:0] irqCount, // requests taken
  output logic [15:0] dmaCount // events taken
);
  logic [2:0] phase;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irqCount <= 16'h0;
      dmaCount <= 16'h0;
      phase <= 3'h0;
      extClk <= 1'b0;
    end
    else
    begin
      irqCount <= irqCount + {15'h0, timerIrq};
      dmaCount <= dmaCount + {15'h0, dmaSyncEvent};
      phase <= extRun ? phase + 3'h1 : 3'h0;
      // clock stands low while not running
      extClk <= extRun & phase[2];
    end
  end
endmodule : timer_far_side

// ---- tb/prescaled_down_timer_pin_tb.sv ----
// self-checking bench for the prescaled down timer
`timescale 1ns/1ps
module prescaled_down_timer_pin_tb;
  import timer_pkg::*;
  localparam logic [15:0] FB_STOP = 16'h1 << B_STOP;
  localparam logic [15:0] FB_LOAD = 16'h1 << B_LOAD;
  localparam logic [15:0] FB_AUTO = 16'h1 << B_AUTO;
  localparam logic [15:0] FB_CLK = 16'h1 << B_CP;
  localparam logic [15:0] FB_SENSE = 16'h1 << B_SENSE;
  localparam logic [15:0] FB_DRIVE = 16'h1 << B_DRIVE;
  localparam logic [15:0] FB_ERR = 16'h1 << B_ERR;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] regAddr = 2'h0;
  logic [DATA_W-1:0] regWdata = 16'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic extRun = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic timerPinOut, timerPinOe, timerIrq, dmaSyncEvent, extClk, padLevel;
  logic [15:0] irqCount, dmaCount, v;
  int badCount = 0;
  int cmpCount = 0;
  int n;
  always #20 sys_clk = ~sys_clk;
  // pad level: our drive wins, else the far side clock
  assign padLevel = timerPinOe ? timerPinOut : extClk;
  prescaled_down_timer_pin dut (.sys_clk(sys_clk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .timerPinIn(padLevel), .timerPinOut(timerPinOut),
    .timerPinOe(timerPinOe), .timerIrq(timerIrq),
    .dmaSyncEvent(dmaSyncEvent));
  timer_far_side far (.sys_clk(sys_clk), .nrst(nrst), .timerIrq(timerIrq),
    .dmaSyncEvent(dmaSyncEvent), .extRun(extRun), .extClk(extClk),
    .irqCount(irqCount), .dmaCount(dmaCount));
  function automatic logic [15:0] cw(input logic [1:0] role);
    cw = {14'h0, role} << B_ROLE_LO;
  endfunction : cw
  task report_and_stop;
    $display("mismatches %0d, comparisons %0d", badCount, cmpCount);
    if (badCount == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      badCount++;
      $display("ERROR %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task rdChk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
    chk(v, exp);
  endtask : rdChk
  task pinChk(input logic oe, input logic lvl);
    chk({14'h0, timerPinOe, timerPinOut}, {14'h0, oe, lvl});
  endtask : pinChk
  task waitIrq(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    while (timerIrq !== 1'b1 && cnt < 400);
    if (cnt >= 400)
    begin
      badCount++;
      report_and_stop();
    end
  endtask : waitIrq
  task doReset;
    nrst <= 1'b0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask : doReset
  // periods chosen keep the total at four input cycles or more
  task start(input logic [3:0] pp, input logic [15:0] mp,
             input logic [15:0] f);
    wr(OFS_CTRL, f | FB_STOP | FB_LOAD);
    wr(OFS_PRESCALE, {12'h0, pp});
    wr(OFS_MAIN_PERIOD, mp);
    rdChk(OFS_PRESCALE, {8'h0, pp, pp});
    rdChk(OFS_MAIN_COUNT, mp);
    wr(OFS_CTRL, f);
  endtask : start
  task tReset;
    rdChk(OFS_CTRL, FB_STOP);
    rdChk(OFS_PRESCALE, {8'h0, RST_PSC, RST_PSC_PER});
    rdChk(OFS_MAIN_PERIOD, RST_TIM_PER);
    rdChk(OFS_MAIN_COUNT, RST_TIM);
    pinChk(1'b0, 1'b0);
  endtask : tReset
  task tClock;
    start(4'h0, 16'h3, FB_AUTO | FB_CLK | cw(ROLE_TOUT));
    @(posedge sys_clk);
    #1;
    pinChk(1'b1, 1'b0);
    waitIrq(n);
    pinChk(1'b1, 1'b1);
    waitIrq(n);
    chk(n[15:0], 16'h4);
    pinChk(1'b1, 1'b0);
    wr(OFS_CTRL, FB_STOP | FB_AUTO | FB_CLK | FB_SENSE | cw(ROLE_TOUT));
    repeat (2) @(posedge sys_clk);
    #1;
    pinChk(1'b1, 1'b1);
    // reload to 3 at the irq, two more steps before the stop lands
    rdChk(OFS_MAIN_COUNT, 16'h1);
    rdChk(OFS_MAIN_COUNT, v);
    wr(OFS_MAIN_COUNT, 16'h5);
    rdChk(OFS_MAIN_COUNT, 16'h5);
  endtask : tClock
  task tPulse;
    int k;
    for (int s = 0; s < 2; s++)
      for (int w = 0; w < 4; w++)
      begin
        start(4'h3, 16'h3, FB_AUTO | (s[0] ? FB_SENSE : 16'h0)
          | ({14'h0, w[1:0]} << B_PW_LO) | cw(ROLE_TOUT));
        waitIrq(n);
        waitIrq(n);
        chk(n[15:0], 16'h10);
        chk({15'h0, dmaSyncEvent}, 16'h1);
        k = 0;
        while (timerPinOut === ~s[0] && k < 20)
        begin
          k++;
          @(posedge sys_clk);
          #1;
        end
        chk(k[15:0], 16'h1 << w);
      end
  endtask : tPulse
  task tGpo;
    wr(OFS_CTRL, FB_STOP | FB_DRIVE | cw(ROLE_GPO));
    repeat (2) @(posedge sys_clk);
    #1;
    pinChk(1'b1, 1'b1);
    wr(OFS_CTRL, FB_STOP | cw(ROLE_GPO));
    repeat (2) @(posedge sys_clk);
    #1;
    pinChk(1'b1, 1'b0);
    rdChk(OFS_CTRL, FB_STOP | cw(ROLE_GPO));
    wr(OFS_CTRL, FB_STOP | cw(ROLE_OFF));
    rdChk(OFS_CTRL, FB_STOP | FB_ERR | cw(ROLE_GPO));
  endtask : tGpo
  task tOneShot;
    start(4'h1, 16'h2, cw(ROLE_GPO));
    waitIrq(n);
    repeat (4) @(posedge sys_clk);
    rdChk(OFS_CTRL, FB_STOP | FB_ERR | cw(ROLE_GPO));
    rdChk(OFS_MAIN_COUNT, 16'h2);
  endtask : tOneShot
  task tExt;
    doReset();
    start(4'h0, 16'h3, FB_AUTO | cw(ROLE_EXT));
    extRun <= 1'b1;
    waitIrq(n);
    waitIrq(n);
    chk(n[15:0], 16'h20);
    chk({15'h0, timerPinOe}, 16'h0);
    extRun <= 1'b0;
    wr(OFS_CTRL, FB_STOP | cw(ROLE_OFF));
    rdChk(OFS_CTRL, FB_STOP | FB_ERR | cw(ROLE_EXT));
    chk(irqCount, 16'h2);
    chk(dmaCount, 16'h2);
  endtask : tExt
  initial
  begin
    doReset();
    tReset();
    tClock();
    tPulse();
    tGpo();
    tOneShot();
    tExt();
    report_and_stop();
  end
endmodule : prescaled_down_timer_pin_tb
